// >>> logic/core_link_if.sv
// Interface joining the status unit to its flag and index helpers.
// Assumes the status unit drives operands and reads results.
`default_nettype none

interface core_link_if;
    core_status_pkg::alu_op_t op;
    logic [15:0] src;
    logic [15:0] dst;
    logic carry_in;
    logic [15:0] result;
    logic c;
    logic f;
    logic z;
    logic l;
    logic n;

    logic idx_req;
    logic idx_high;
    logic idx_abs;
    logic idx_long;
    logic narrow;
    logic [31:0] pair;
    logic [19:0] disp;
    logic [31:0] base_low;
    logic [31:0] base_high;
    logic [31:0] ret_link;
    logic [31:0] idx_addr;
    logic idx_valid;
    logic idx_fault;
    logic [31:0] ext_link;

    modport top_alu (output op, src, dst, carry_in,
                     input result, c, f, z, l, n);
    modport alu (input op, src, dst, carry_in,
                 output result, c, f, z, l, n);
    modport top_idx (output idx_req, idx_high, idx_abs, idx_long, narrow,
                     pair, disp, base_low, base_high, ret_link,
                     input idx_addr, idx_valid, idx_fault, ext_link);
    modport idx (input idx_req, idx_high, idx_abs, idx_long, narrow,
                 pair, disp, base_low, base_high, ret_link,
                 output idx_addr, idx_valid, idx_fault, ext_link);
endinterface

`default_nettype wire

// >>> logic/core_status_pkg.sv
// Constants and types shared by the state word, setup word and
// index address logic of the core.
// Assumes a single core clock and a synchronous reset.
`default_nettype none

package core_status_pkg;

    // ****************************************************************
    // State word layout
    // ****************************************************************
    localparam int PSW_W = 16;
    localparam int PSW_C = 0;
    localparam int PSW_T = 1;
    localparam int PSW_L = 2;
    localparam int PSW_U = 3;
    localparam int PSW_F = 5;
    localparam int PSW_Z = 6;
    localparam int PSW_N = 7;
    localparam int PSW_E = 9;
    localparam int PSW_P = 10;
    localparam int PSW_I = 11;
    // Writable bits; 4, 8 and 12..15 are held at zero
    localparam logic [15:0] PSW_WR_MASK = 16'h0eef;
    localparam logic [15:0] PSW_RESET = 16'h0200;

    // ****************************************************************
    // Setup word layout
    // ****************************************************************
    localparam int CFG_WIDE = 8;
    localparam int CFG_NARROW = 9;
    localparam logic [15:0] CFG_WR_MASK = 16'h0300;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // ****************************************************************
    // Core register selectors for the load-core-register port
    // ****************************************************************
    localparam logic [1:0] SEL_PSW = 2'h0;
    localparam logic [1:0] SEL_CFG = 2'h1;
    localparam logic [1:0] SEL_USP = 2'h2;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int ADDR_W = 32;
    localparam int DISP_SHORT_W = 14;
    localparam int DISP_LONG_W = 20;
    localparam int DEPTH_W = 4;

    typedef enum logic [2:0] {
        OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMP
    } alu_op_t;

    typedef enum logic [3:0] {
        CC_EQ, CC_NE, CC_CS, CC_CC, CC_LO, CC_HS, CC_LT, CC_GE,
        CC_FS, CC_FC, CC_HI, CC_LS, CC_GT, CC_LE, CC_UC, CC_NV
    } cond_t;

endpackage

`default_nettype wire

// >>> logic/core_status_unit.sv
// Status and setup words of the core with trace, mode, interrupt
// enable, branch condition and index address logic.
// Assumes the sequencer pulses each event strobe for one enabled cycle.
`default_nettype none

// Summary of operation
// - Carry reflects add carry or subtract borrow
// - Trace raises step exception, not in handlers
// - Pending copy at start gives one step
// - Low flag is unsigned second-below-first
// - User flag selects the unprivileged stack pointer
// - User mode by jump, state word write or return; exceptions supervise
// - Unprivileged pointer access in user mode faults
// - General flag reports signed arithmetic overflow
// - Zero flag set when compared operands equal
// - Negative flag is signed second-below-first
// - Irq on sets, irq off clears local enable
// - Maskable interrupts need both enables set
// - Global enable cleared on irq, set on irq return
// - Branch conditions decode the five flags
// - Reset clears low twelve bits, local enable set
// - Warm reset saves old state word first
// - Bits four and eight zero; top reserved
// - Flags change only under affecting instructions
// - Reset clears setup word; cache bits reserved
// - Wide vector select picks entry width
// - Narrow pair mode pairs low halves
// - Index mode adds base, needs narrow off
module core_status_unit (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic WARM_RST,
    input wire logic INSN_START,
    input wire logic INSN_END,
    input wire logic ALU_UPDATE,
    input wire logic [2:0] ALU_OP,
    input wire logic [15:0] ALU_SRC,
    input wire logic [15:0] ALU_DST,
    output logic [15:0] ALU_RESULT,
    input wire logic IRQ_ON,
    input wire logic IRQ_OFF,
    input wire logic JUMP_TO_UNPRIVILEGED,
    input wire logic EXC_ENTER,
    input wire logic EXC_IS_IRQ,
    input wire logic EXC_RETURN,
    input wire logic RET_IS_IRQ,
    input wire logic [15:0] RET_STATE,
    input wire logic PREG_WR,
    input wire logic PREG_RD,
    input wire logic [1:0] PREG_SEL,
    input wire logic [31:0] PREG_WDATA,
    output logic [31:0] PREG_RDATA,
    input wire logic [3:0] COND_CODE,
    output logic BRANCH_TAKEN,
    output logic STEP_EXCEPTION,
    output logic ILLEGAL_OP_EXCEPTION,
    output logic MASKABLE_OK,
    output logic STACK_USER,
    output logic IN_HANDLER,
    output logic [15:0] STATE_WORD,
    output logic [15:0] SETUP_WORD,
    output logic WIDE_VECTOR,
    output logic NARROW_PAIR,
    output logic [31:0] USP_VALUE,
    output logic SAVE_REG_WE,
    output logic [15:0] SAVE_REG_DATA,
    input wire logic IDX_REQ,
    input wire logic IDX_HIGH,
    input wire logic IDX_ABS,
    input wire logic IDX_LONG,
    input wire logic [31:0] IDX_PAIR,
    input wire logic [19:0] IDX_DISP,
    input wire logic [31:0] INDEX_BASE_LOW,
    input wire logic [31:0] INDEX_BASE_HIGH,
    input wire logic [31:0] RETURN_LINK,
    output logic [31:0] IDX_ADDR,
    output logic IDX_VALID,
    output logic IDX_FAULT,
    output logic [31:0] EXT_RETURN_LINK
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [15:0] psw;
        logic [15:0] cfg;
        logic [31:0] unprivileged_stack_pointer;
        logic [3:0] depth;
        logic [15:0] result;
        logic branch;
        logic step;
        logic illegal;
        logic save_we;
        logic [15:0] save_data;
        logic [31:0] rdata;
    } status_state_t;

    status_state_t s;
    status_state_t next_s;
    core_link_if lnk ();

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic cond_met(input logic [3:0] code,
                                      input logic [15:0] w);
        logic z;
        logic c;
        logic l;
        logic n;
        logic f;
        z = w[core_status_pkg::PSW_Z];
        c = w[core_status_pkg::PSW_C];
        l = w[core_status_pkg::PSW_L];
        n = w[core_status_pkg::PSW_N];
        f = w[core_status_pkg::PSW_F];
        case (core_status_pkg::cond_t'(code))
            core_status_pkg::CC_EQ: cond_met = z;
            core_status_pkg::CC_NE: cond_met = !z;
            core_status_pkg::CC_CS: cond_met = c;
            core_status_pkg::CC_CC: cond_met = !c;
            core_status_pkg::CC_LO: cond_met = l;
            core_status_pkg::CC_HS: cond_met = !l;
            core_status_pkg::CC_LT: cond_met = n;
            core_status_pkg::CC_GE: cond_met = !n;
            core_status_pkg::CC_FS: cond_met = f;
            core_status_pkg::CC_FC: cond_met = !f;
            core_status_pkg::CC_HI: cond_met = !l && !z;
            core_status_pkg::CC_LS: cond_met = l || z;
            core_status_pkg::CC_GT: cond_met = !n && !z;
            core_status_pkg::CC_LE: cond_met = n || z;
            core_status_pkg::CC_UC: cond_met = 1'b1;
            default: cond_met = 1'b0;
        endcase
    endfunction

    // Masks off constant-zero and reserved positions
    function automatic logic [15:0] clean_psw(input logic [15:0] w);
        clean_psw = w & core_status_pkg::PSW_WR_MASK;
    endfunction

    // ****************************************************************
    // Helper connections
    // ****************************************************************
    assign lnk.op = core_status_pkg::alu_op_t'(ALU_OP);
    assign lnk.src = ALU_SRC;
    assign lnk.dst = ALU_DST;
    // Plain add and subtract ignore the stored carry
    assign lnk.carry_in = ((lnk.op == core_status_pkg::OP_ADDC) ||
                           (lnk.op == core_status_pkg::OP_SUBC)) &&
                          s.psw[core_status_pkg::PSW_C];
    assign lnk.idx_req = IDX_REQ;
    assign lnk.idx_high = IDX_HIGH;
    assign lnk.idx_abs = IDX_ABS;
    assign lnk.idx_long = IDX_LONG;
    assign lnk.narrow = s.cfg[core_status_pkg::CFG_NARROW];
    assign lnk.pair = IDX_PAIR;
    assign lnk.disp = IDX_DISP;
    assign lnk.base_low = INDEX_BASE_LOW;
    assign lnk.base_high = INDEX_BASE_HIGH;
    assign lnk.ret_link = RETURN_LINK;

    flag_calc u_flag_calc (
        .lnk(lnk.alu)
    );

    index_addr u_index_addr (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .lnk(lnk.idx)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic user;
        logic cmp;
        next_s = s;
        user = s.psw[core_status_pkg::PSW_U];
        cmp = (lnk.op == core_status_pkg::OP_CMP);
        next_s.step = 1'b0;
        next_s.illegal = 1'b0;
        next_s.save_we = 1'b0;
        next_s.branch = cond_met(COND_CODE, s.psw);

        // Flags move only on their own strobes, else they hold
        if (ALU_UPDATE) begin
            if (cmp) begin
                next_s.psw[core_status_pkg::PSW_Z] = lnk.z;
                next_s.psw[core_status_pkg::PSW_L] = lnk.l;
                next_s.psw[core_status_pkg::PSW_N] = lnk.n;
            end else begin
                next_s.psw[core_status_pkg::PSW_C] = lnk.c;
                next_s.psw[core_status_pkg::PSW_F] = lnk.f;
                next_s.result = lnk.result;
            end
        end

        if (IRQ_ON) begin
            next_s.psw[core_status_pkg::PSW_E] = 1'b1;
        end else if (IRQ_OFF) begin
            next_s.psw[core_status_pkg::PSW_E] = 1'b0;
        end

        // Handlers never trace, so pending is not armed inside one
        if (INSN_START) begin
            next_s.psw[core_status_pkg::PSW_P] =
                s.psw[core_status_pkg::PSW_T] && (s.depth == 4'h0);
        end
        if (INSN_END && s.psw[core_status_pkg::PSW_P]) begin
            next_s.psw[core_status_pkg::PSW_P] = 1'b0;
            next_s.step = (s.depth == 4'h0);
        end

        if (JUMP_TO_UNPRIVILEGED) begin
            next_s.psw[core_status_pkg::PSW_U] = 1'b1;
        end

        // Load-core-register access; state word frozen in user mode
        if (PREG_WR) begin
            case (PREG_SEL)
                core_status_pkg::SEL_PSW: begin
                    if (!user) begin
                        next_s.psw = clean_psw(PREG_WDATA[15:0]);
                    end
                end
                core_status_pkg::SEL_CFG: begin
                    if (!user) begin
                        next_s.cfg = PREG_WDATA[15:0] &
                                     core_status_pkg::CFG_WR_MASK;
                    end
                end
                core_status_pkg::SEL_USP: begin
                    if (user) begin
                        next_s.illegal = 1'b1;
                    end else begin
                        next_s.unprivileged_stack_pointer = PREG_WDATA;
                    end
                end
                default: begin
                end
            endcase
        end
        if (PREG_RD) begin
            case (PREG_SEL)
                core_status_pkg::SEL_PSW: begin
                    next_s.rdata = {16'h0000, s.psw};
                end
                core_status_pkg::SEL_CFG: begin
                    next_s.rdata = {16'h0000, s.cfg};
                end
                core_status_pkg::SEL_USP: begin
                    if (user) begin
                        next_s.illegal = 1'b1;
                        next_s.rdata = 32'h00000000;
                    end else begin
                        next_s.rdata = s.unprivileged_stack_pointer;
                    end
                end
                default: begin
                    next_s.rdata = 32'h00000000;
                end
            endcase
        end

        // Return restores the popped word; entry wins if both arrive
        if (EXC_RETURN) begin
            next_s.psw = clean_psw(RET_STATE);
            if (RET_IS_IRQ) begin
                next_s.psw[core_status_pkg::PSW_I] = 1'b1;
            end
            if (s.depth != 4'h0) begin
                next_s.depth = s.depth - 4'h1;
            end
        end
        if (EXC_ENTER) begin
            next_s.psw[core_status_pkg::PSW_U] = 1'b0;
            next_s.psw[core_status_pkg::PSW_P] = 1'b0;
            if (EXC_IS_IRQ) begin
                next_s.psw[core_status_pkg::PSW_I] = 1'b0;
            end
            // Saturate so deep nesting cannot wrap back to zero
            if (s.depth != 4'hf) begin
                next_s.depth = s.depth + 4'h1;
            end
        end

        // Warm reset: old word goes out before reinitialising
        if (WARM_RST) begin
            next_s.save_we = 1'b1;
            next_s.save_data = s.psw;
            next_s.psw = core_status_pkg::PSW_RESET;
            next_s.cfg = core_status_pkg::CFG_RESET;
            next_s.depth = 4'h0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s <= '0;
            s.psw <= core_status_pkg::PSW_RESET;
            s.cfg <= core_status_pkg::CFG_RESET;
        end else if (CE) begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign ALU_RESULT = s.result;
    assign PREG_RDATA = s.rdata;
    assign BRANCH_TAKEN = s.branch;
    assign STEP_EXCEPTION = s.step;
    assign ILLEGAL_OP_EXCEPTION = s.illegal;
    assign MASKABLE_OK = s.psw[core_status_pkg::PSW_E] &&
                         s.psw[core_status_pkg::PSW_I];
    assign STACK_USER = s.psw[core_status_pkg::PSW_U];
    assign IN_HANDLER = (s.depth != 4'h0);
    assign STATE_WORD = s.psw;
    assign SETUP_WORD = s.cfg;
    // Narrow entries limit handlers to the low 128K; base unaffected
    assign WIDE_VECTOR = s.cfg[core_status_pkg::CFG_WIDE];
    assign NARROW_PAIR = s.cfg[core_status_pkg::CFG_NARROW];
    assign USP_VALUE = s.unprivileged_stack_pointer;
    assign SAVE_REG_WE = s.save_we;
    assign SAVE_REG_DATA = s.save_data;
    assign IDX_ADDR = lnk.idx_addr;
    assign IDX_VALID = lnk.idx_valid;
    assign IDX_FAULT = lnk.idx_fault;
    assign EXT_RETURN_LINK = lnk.ext_link;
endmodule // core_status_unit

`default_nettype wire

// >>> logic/flag_calc.sv
// Combinational arithmetic and compare flag generator.
// Assumes the caller registers whatever it keeps.
`default_nettype none

module flag_calc (
    core_link_if.alu lnk
);
    logic [16:0] wide;
    logic sub;

    always_comb begin
        sub = (lnk.op >= core_status_pkg::OP_SUB);
        if (sub) begin
            wide = {1'b0, lnk.dst} - {1'b0, lnk.src} - 17'(lnk.carry_in);
        end else begin
            wide = {1'b0, lnk.dst} + {1'b0, lnk.src} + 17'(lnk.carry_in);
        end
        lnk.result = wide[15:0];
        lnk.c = wide[16];
        // Overflow: operand signs allow it, result sign shows it
        lnk.f = ((lnk.dst[15] ^ lnk.src[15]) == sub) &&
                (wide[15] != lnk.dst[15]);
        lnk.z = (lnk.dst == lnk.src);
        lnk.l = (lnk.dst < lnk.src);
        lnk.n = ($signed(lnk.dst) < $signed(lnk.src));
    end
endmodule // flag_calc

`default_nettype wire

// >>> logic/index_addr.sv
// Index mode address former and short-register return link pairing.
// Assumes base registers are presented by the caller each request.
`default_nettype none

module index_addr (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    core_link_if.idx lnk
);
    typedef struct packed {
        logic [31:0] addr;
        logic valid;
        logic fault;
        logic [31:0] link;
    } idx_state_t;

    idx_state_t s;
    idx_state_t next_s;
    logic [31:0] base;
    logic [31:0] offs;

    always_comb begin
        next_s = s;
        base = lnk.idx_high ? lnk.base_high : lnk.base_low;
        if (lnk.idx_abs) begin
            offs = {12'h000, lnk.disp};
        end else if (lnk.idx_long) begin
            offs = lnk.pair + {12'h000, lnk.disp};
        end else begin
            offs = lnk.pair + {18'h00000, lnk.disp[13:0]};
        end
        next_s.valid = 1'b0;
        next_s.fault = 1'b0;
        if (lnk.idx_req) begin
            if (lnk.narrow) begin
                next_s.fault = 1'b1;
            end else begin
                next_s.addr = base + offs;
                next_s.valid = 1'b1;
            end
        end
        // Short-register mode pairs the low halves into one link
        if (lnk.narrow) begin
            next_s.link = {lnk.base_high[15:0], lnk.ret_link[15:0]};
        end else begin
            next_s.link = lnk.ret_link;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign lnk.idx_addr = s.addr;
    assign lnk.idx_valid = s.valid;
    assign lnk.idx_fault = s.fault;
    assign lnk.ext_link = s.link;
endmodule // index_addr

`default_nettype wire

// >>> test/core_status_props.sv
// Checker for state word, interrupt enables, modes and warm reset.
// Assumes it is bound to core_status_unit and sees only its ports.
`default_nettype none

module core_status_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic WARM_RST,
    input wire logic IRQ_ON,
    input wire logic IRQ_OFF,
    input wire logic EXC_ENTER,
    input wire logic EXC_IS_IRQ,
    input wire logic EXC_RETURN,
    input wire logic RET_IS_IRQ,
    input wire logic PREG_WR,
    input wire logic PREG_RD,
    input wire logic [1:0] PREG_SEL,
    input wire logic [15:0] STATE_WORD,
    input wire logic [15:0] SETUP_WORD,
    input wire logic MASKABLE_OK,
    input wire logic STACK_USER,
    input wire logic SAVE_REG_WE,
    input wire logic [15:0] SAVE_REG_DATA,
    input wire logic ILLEGAL_OP_EXCEPTION,
    input wire logic NARROW_PAIR,
    input wire logic IDX_REQ,
    input wire logic IDX_FAULT,
    input wire logic IDX_VALID
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // ****************************************************************
    // Properties
    // ****************************************************************
    reset_value_a: assert property (
        $rose(RST_N) |-> STATE_WORD == 16'h0200 && SETUP_WORD == 16'h0000)
        else $error("Bad reset words");
    fixed_zero_a: assert property (
        (STATE_WORD & 16'hf110) == 16'h0000)
        else $error("Zero bits set");
    irq_on_a: assert property (
        CE && IRQ_ON && !PREG_WR && !EXC_RETURN && !WARM_RST |=> STATE_WORD[9])
        else $error("Local enable not set");
    irq_off_a: assert property (
        CE && IRQ_OFF && !IRQ_ON && !PREG_WR && !EXC_RETURN && !WARM_RST
        |=> !STATE_WORD[9]) else $error("Local enable not cleared");
    mask_gate_a: assert property (
        MASKABLE_OK == (STATE_WORD[9] && STATE_WORD[11]))
        else $error("Mask gate wrong");
    enter_super_a: assert property (
        CE && EXC_ENTER && !WARM_RST
        |=> !STACK_USER && !(STATE_WORD[11] && $past(EXC_IS_IRQ)))
        else $error("Bad entry");
    irq_return_a: assert property (
        CE && EXC_RETURN && RET_IS_IRQ && !EXC_ENTER && !WARM_RST
        |=> STATE_WORD[11]) else $error("I not restored");
    warm_save_a: assert property (
        CE && WARM_RST |=> SAVE_REG_WE && STATE_WORD == 16'h0200
        && SAVE_REG_DATA == $past(STATE_WORD)) else $error("Warm save wrong");
    usp_guard_a: assert property (
        CE && STACK_USER && PREG_SEL == 2'h2 && (PREG_RD || PREG_WR)
        && !WARM_RST |=> ILLEGAL_OP_EXCEPTION) else $error("No illegal op");
    narrow_fault_a: assert property (
        CE && IDX_REQ && NARROW_PAIR && !WARM_RST |=> IDX_FAULT && !IDX_VALID)
        else $error("Index not refused");
endmodule // core_status_props

bind core_status_unit core_status_props i_core_status_props (.*);

`default_nettype wire

// >>> test/core_status_unit_test.sv
// Self-checking bench for the core status unit.
// Assumes unit, package and checker compile first.
`default_nettype none

module core_status_unit_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef enum int {S_WARM, S_START, S_END, S_ALU, S_ON, S_OFF, S_JUMP,
        S_ENTER, S_RET, S_WR, S_RD, S_IDX} strobe_t;
    logic CLK, RST_N, CE, WARM_RST, INSN_START, INSN_END, ALU_UPDATE;
    logic IRQ_ON, IRQ_OFF, JUMP_TO_UNPRIVILEGED, EXC_ENTER, EXC_IS_IRQ, EXC_RETURN;
    logic RET_IS_IRQ, PREG_WR, PREG_RD, BRANCH_TAKEN, STEP_EXCEPTION;
    logic ILLEGAL_OP_EXCEPTION, MASKABLE_OK, STACK_USER, IN_HANDLER;
    logic WIDE_VECTOR, NARROW_PAIR, SAVE_REG_WE, IDX_REQ, IDX_HIGH;
    logic IDX_ABS, IDX_LONG, IDX_VALID, IDX_FAULT;
    logic [1:0] PREG_SEL;
    logic [2:0] ALU_OP;
    logic [3:0] COND_CODE;
    logic [11:0] strb;
    logic [15:0] ALU_SRC, ALU_DST, RET_STATE, ALU_RESULT, STATE_WORD;
    logic [15:0] SETUP_WORD, SAVE_REG_DATA, sw;
    logic [19:0] IDX_DISP;
    logic [31:0] PREG_WDATA, PREG_RDATA, USP_VALUE, IDX_PAIR, IDX_ADDR;
    logic [31:0] INDEX_BASE_LOW, INDEX_BASE_HIGH, RETURN_LINK, a;
    logic [31:0] EXT_RETURN_LINK;
    int miscompares = 0;
    int samples_checked = 0;

    assign {IDX_REQ, PREG_RD, PREG_WR, EXC_RETURN, EXC_ENTER, JUMP_TO_UNPRIVILEGED,
        IRQ_OFF, IRQ_ON, ALU_UPDATE, INSN_END, INSN_START, WARM_RST} = strb;

    core_status_unit i_core_status_unit (.*);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pulse(input strobe_t k);
        @(posedge CLK);
        strb[k] <= 1'b1;
        @(posedge CLK);
        strb[k] <= 1'b0;
        #1;
    endtask

    task automatic close_out;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic [15:0] alu_flags(input logic [2:0] op,
        input logic [15:0] s, input logic [15:0] d, input logic [15:0] w);
        int u;
        int v;
        logic [15:0] r;
        r = w;
        u = (op == 3'h1 || op == 3'h3) ? int'(w[0]) : 0;
        if (op == 3'h4) begin
            r[6] = d == s;
            r[2] = d < s;
            r[7] = $signed(d) < $signed(s);
        end else begin
            if (op < 3'h2) begin
                r[0] = int'(d) + int'(s) + u > 65535;
                v = int'($signed(d)) + int'($signed(s)) + u;
            end else begin
                r[0] = int'(d) - int'(s) - u < 0;
                v = int'($signed(d)) - int'($signed(s)) - u;
            end
            r[5] = v > 32767 || v < -32768;
        end
        return r;
    endfunction

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    initial begin
        repeat (3000) @(posedge CLK);
        miscompares++;
        close_out;
    end

    initial begin
        a = $urandom(32'ha7b0570d);
        {RST_N, strb, EXC_IS_IRQ, RET_IS_IRQ, PREG_SEL, PREG_WDATA} <= '0;
        {ALU_OP, ALU_SRC, ALU_DST, RET_STATE, COND_CODE, IDX_PAIR} <= '0;
        {IDX_HIGH, IDX_ABS, IDX_LONG, IDX_DISP, RETURN_LINK} <= '0;
        {INDEX_BASE_LOW, INDEX_BASE_HIGH} <= '0;
        CE <= 1'b1;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        #1;
        chk({SETUP_WORD, STATE_WORD}, 32'h0000_0200);
        pulse(S_OFF);
        chk({MASKABLE_OK, STATE_WORD}, 17'h0_0000);
        pulse(S_ON);
        chk(STATE_WORD, 16'h0200);
        @(posedge CLK);
        PREG_SEL <= 2'h1;
        PREG_WDATA <= 32'h0000_03c3;
        pulse(S_WR);
        chk({WIDE_VECTOR, NARROW_PAIR, SETUP_WORD}, 18'h3_0300);
        @(posedge CLK);
        RETURN_LINK <= $urandom;
        INDEX_BASE_HIGH <= $urandom;
        pulse(S_IDX);
        chk({IDX_FAULT, IDX_VALID}, 2'h2);
        chk(EXT_RETURN_LINK, {INDEX_BASE_HIGH[15:0], RETURN_LINK[15:0]});
        @(posedge CLK);
        PREG_WDATA <= 32'h0;
        pulse(S_WR);
        chk(SETUP_WORD, 16'h0000);
        repeat (12) begin
            @(posedge CLK);
            {IDX_HIGH, IDX_ABS, IDX_LONG} <= 3'($urandom);
            IDX_PAIR <= $urandom;
            IDX_DISP <= 20'($urandom);
            INDEX_BASE_LOW <= $urandom;
            INDEX_BASE_HIGH <= $urandom;
            pulse(S_IDX);
            a = IDX_ABS ? 32'(IDX_DISP) : IDX_PAIR
                + (IDX_LONG ? 32'(IDX_DISP) : 32'(IDX_DISP[13:0]));
            chk(IDX_ADDR, a + (IDX_HIGH ? INDEX_BASE_HIGH : INDEX_BASE_LOW));
            chk({IDX_VALID, EXT_RETURN_LINK[30:0]}, {1'b1, RETURN_LINK[30:0]});
        end
        @(posedge CLK);
        PREG_SEL <= 2'h0;
        PREG_WDATA <= 32'h0000_0ff7;
        pulse(S_WR);
        sw = 16'h0ee7;
        chk({MASKABLE_OK, STATE_WORD}, {1'b1, sw});
        for (int i = 0; i < 40; i++) begin
            @(posedge CLK);
            ALU_OP <= i < 5 ? 3'(i) : 3'($urandom_range(4, 0));
            ALU_SRC <= i[1:0] == 2'h0 ? 16'h8000 : 16'($urandom);
            ALU_DST <= i[1] == 1'b0 ? 16'h8000 : 16'($urandom);
            pulse(S_ALU);
            if (ALU_OP < 3'h4) a[15:0] = ALU_OP[1] ?
                ALU_DST - ALU_SRC - (ALU_OP[0] & sw[0]) :
                ALU_DST + ALU_SRC + (ALU_OP[0] & sw[0]);
            sw = alu_flags(ALU_OP, ALU_SRC, ALU_DST, sw);
            chk(STATE_WORD, sw);
            chk(ALU_RESULT, a[15:0]);
            @(posedge CLK);
            #1;
            chk(BRANCH_TAKEN, sw[6]);
        end
        pulse(S_START);
        pulse(S_END);
        chk(STEP_EXCEPTION, 1'b1);
        pulse(S_END);
        chk(STEP_EXCEPTION, 1'b0);
        @(posedge CLK);
        PREG_SEL <= 2'h2;
        PREG_WDATA <= $urandom;
        pulse(S_WR);
        a = PREG_WDATA;
        chk(USP_VALUE, a);
        pulse(S_RD);
        chk(PREG_RDATA, a);
        @(posedge CLK);
        EXC_IS_IRQ <= 1'b1;
        pulse(S_ENTER);
        sw[11:10] = 2'h0;
        chk({IN_HANDLER, STATE_WORD}, {1'b1, sw});
        pulse(S_START);
        pulse(S_END);
        chk(STEP_EXCEPTION, 1'b0);
        @(posedge CLK);
        RET_IS_IRQ <= 1'b1;
        RET_STATE <= 16'hf7f5;
        pulse(S_RET);
        chk(STATE_WORD, 16'h0ee5);
        pulse(S_JUMP);
        chk(STACK_USER, 1'b1);
        pulse(S_RD);
        chk(ILLEGAL_OP_EXCEPTION, 1'b1);
        pulse(S_WARM);
        chk({SAVE_REG_WE, SAVE_REG_DATA}, 17'h1_0eed);
        chk(STATE_WORD, 16'h0200);
        chk(USP_VALUE, a);
        close_out;
    end
endmodule // core_status_unit_test

`default_nettype wire
